// ==== bench/scp_client_sva.sv ====
/*
 * checker for the serial client port: bus reset timing, data release, clock never held.
 * assumes it sees only the client's top ports and is bound to every client instance.
 */
`timescale 1ns/1ps
module scp_client_sva #(
   parameter TIMEOUT_CYC = 200,
   parameter IDLE_CYC = 50
) (
   input wire REF_CLK_I,
   input wire RST_B_I,
   input wire SERIAL_BUS_CLOCK_I,
   input wire SDA_I,
   input wire TIMEOUT_DISABLE_BIT_I,
   input wire SLEEP_I,
   input wire SDA_O,
   input wire SDA_OE_O,
   input wire SCL_OE_O,
   input wire BUS_RESET_O
);
   // ==========================================
   // helper counters on the raw pin levels
   // ==========================================
   int low_cnt; // cycles the bus clock has been low, timeout on
   int high_cnt; // cycles both lines high, idle reset on
   logic fired; // a bus reset pulse seen during this run

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_B_I);

   // counters saturate just past the limit, so they stay small
   always @(posedge REF_CLK_I) begin
      if (!RST_B_I || TIMEOUT_DISABLE_BIT_I || SERIAL_BUS_CLOCK_I) low_cnt <= 0;
      else if (low_cnt < TIMEOUT_CYC + 9) low_cnt <= low_cnt + 1;
      if (!RST_B_I || TIMEOUT_DISABLE_BIT_I || SLEEP_I || !(SERIAL_BUS_CLOCK_I && SDA_I)) high_cnt <= 0;
      else if (high_cnt < IDLE_CYC + 9) high_cnt <= high_cnt + 1;
      // raw pins lead the synchronised view, so a run starting clears the flag
      if (!RST_B_I || (low_cnt == 0 && high_cnt == 0)) fired <= 1'b0;
      else if (BUS_RESET_O) fired <= 1'b1;
   end

   // ==========================================
   // assertions
   // ==========================================
   a_scl_free: assert property (SCL_OE_O == 1'b0)
      else $error("client drives the bus clock");
   a_drive_low: assert property (SDA_OE_O |-> SDA_O == 1'b0)
      else $error("data driven high");
   a_pulse_single: assert property (BUS_RESET_O |=> !BUS_RESET_O)
      else $error("bus reset longer than one cycle");
   a_off_when_disabled: assert property (
      TIMEOUT_DISABLE_BIT_I && $past(TIMEOUT_DISABLE_BIT_I) && $past(TIMEOUT_DISABLE_BIT_I, 2) |-> !BUS_RESET_O)
      else $error("bus reset while disabled");
   a_release_data: assert property (BUS_RESET_O |=> !SDA_OE_O [*4])
      else $error("data held after bus reset");
   a_no_early_reset: assert property (
      BUS_RESET_O |-> (low_cnt >= TIMEOUT_CYC - 1 || high_cnt >= IDLE_CYC - 1))
      else $error("bus reset without its cause");
   a_timeout_fires: assert property (low_cnt == TIMEOUT_CYC + 8 |-> fired)
      else $error("low clock timeout missed");
   a_idle_fires: assert property (high_cnt == IDLE_CYC + 8 |-> fired)
      else $error("idle reset missed");
   a_data_on_low: assert property ($changed(SDA_OE_O) |-> !SERIAL_BUS_CLOCK_I)
      else $error("data changed while bus clock high");
endmodule // scp_client_sva

bind scp_client scp_client_sva #(.TIMEOUT_CYC(TIMEOUT_CYC), .IDLE_CYC(IDLE_CYC)) u_sva (
   .REF_CLK_I(REF_CLK_I), .RST_B_I(RST_B_I), .SERIAL_BUS_CLOCK_I(SERIAL_BUS_CLOCK_I),
   .SDA_I(SDA_I), .TIMEOUT_DISABLE_BIT_I(TIMEOUT_DISABLE_BIT_I), .SLEEP_I(SLEEP_I),
   .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .SCL_OE_O(SCL_OE_O), .BUS_RESET_O(BUS_RESET_O));

// ==== bench/scp_client_test.sv ====
/*
 * bench top for the serial client port: byte, block, pointer, foreign address and bus resets.
 * assumes the host model on the wires and a pull-up on the data line.
 */
`timescale 1ns/1ps
module scp_client_test;
   // ==========================================
   // clock, reset, wires
   // ==========================================
   localparam logic [6:0] ADDR = 7'h2a; // client address under test
   logic clk = 1'b0; // core clock, 4 ns
   logic rst_b = 1'b0; // synchronous reset, low active
   logic timeout_disable_bit = 1'b1; // both bus resets off
   logic sleep = 1'b0; // sleep state level
   logic host_scl; // host bus clock
   logic host_low; // host pulls data low
   wire sda_o;
   wire sda_oe;
   wire scl_oe;
   wire bus_rst;
   wire scl = host_scl & ~scl_oe; // resolved even though client never pulls
   wire sda = ~(host_low | sda_oe); // pull-up wins when nobody pulls
   int err_count = 0;
   int samples_checked = 0;
   int pulses = 0; // bus reset pulses seen

   initial forever #2 clk = ~clk;
   always @(posedge clk) if (bus_rst === 1'b1) pulses <= pulses + 1;

   scp_client #(.OWN_ADDR(ADDR), .TIMEOUT_CYC(200), .IDLE_CYC(50)) dut (
      .REF_CLK_I(clk), .RST_B_I(rst_b), .SERIAL_BUS_CLOCK_I(scl), .SDA_I(sda),
      .TIMEOUT_DISABLE_BIT_I(timeout_disable_bit), .SLEEP_I(sleep), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
      .SCL_OE_O(scl_oe), .BUS_RESET_O(bus_rst));
   scp_host_model host (.clk_i(clk), .sda_i(sda), .scl_o(host_scl), .sda_low_o(host_low));

   // ==========================================
   // shared tasks
   // ==========================================
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t ns: %s", $time, what);
      end
   endtask

   // writes n bytes base, base+1.. from idx; n of 0 only loads the pointer
   task automatic put(input logic [7:0] idx, input logic [7:0] base, input int n);
      logic a;
      host.start();
      host.wbyte({ADDR, 1'b0}, a);
      check({7'h00, a}, 8'h01, "write address ack");
      host.wbyte(idx, a);
      check({7'h00, a}, 8'h01, "index ack");
      for (int i = 0; i < n; i++) begin
         host.wbyte(base + 8'(i), a);
         check({7'h00, a}, 8'h01, "data ack");
      end
      host.stop();
   endtask

   // reads n bytes, optionally after loading the pointer with a repeated start
   task automatic get(input logic use_idx, input logic [7:0] idx, input logic [7:0] base, input int n);
      logic a;
      logic [7:0] d;
      if (use_idx) begin
         host.start();
         host.wbyte({ADDR, 1'b0}, a);
         host.wbyte(idx, a);
      end
      host.start();
      host.wbyte({ADDR, 1'b1}, a);
      check({7'h00, a}, 8'h01, "read address ack");
      for (int i = 0; i < n; i++) begin
         host.rbyte(i == n - 1, d);
         check(d, base + 8'(i), "read data");
      end
      host.stop();
   endtask

   task automatic results();
      if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // ==========================================
   // scenarios
   // ==========================================
   task automatic s_block();
      put(8'h40, 8'h1e, 2);
      get(1'b1, 8'h40, 8'h1e, 1);
      put(8'hfe, 8'h71, 4);
      get(1'b1, 8'hfe, 8'h71, 4);
   endtask

   // index only, then reads without index follow the kept pointer
   task automatic s_ptr();
      put(8'h40, 8'h00, 0);
      get(1'b0, 8'h00, 8'h1e, 1);
      get(1'b0, 8'h00, 8'h1e, 1);
   endtask

   task automatic s_foreign();
      logic a;
      host.start();
      host.wbyte({ADDR ^ 7'h01, 1'b0}, a);
      check({7'h00, a}, 8'h00, "foreign address acked");
      host.wbyte(8'h40, a);
      host.wbyte(8'h99, a);
      check({7'h00, a}, 8'h00, "foreign data acked");
      host.stop();
      get(1'b1, 8'h40, 8'h1e, 1);
   endtask

   // clock held low mid read, then idle with and without sleep
   task automatic s_reset();
      logic a;
      put(8'h20, 8'h00, 1);
      put(8'h20, 8'h00, 0);
      sleep = 1'b1;
      timeout_disable_bit = 1'b0;
      check(8'(pulses), 8'h00, "bus reset while disabled");
      host.start();
      host.wbyte({ADDR, 1'b1}, a);
      host.q(6);
      check({7'h00, sda_oe}, 8'h01, "first read bit not driven");
      host.q(300);
      check(8'(pulses), 8'h01, "timeout pulse");
      check({7'h00, sda_oe}, 8'h00, "data not released");
      host.release_bus();
      get(1'b1, 8'h20, 8'h00, 1);
      host.q(80);
      check(8'(pulses), 8'h01, "idle reset in sleep");
      sleep = 1'b0;
      host.q(80);
      check(8'(pulses), 8'h02, "idle reset");
      timeout_disable_bit = 1'b1;
   endtask

   // ==========================================
   // main sequence and hang guard
   // ==========================================
   initial begin
      repeat (20) @(posedge clk);
      #1;
      rst_b = 1'b1;
      host.q(5);
      s_block();
      s_ptr();
      s_foreign();
      s_reset();
      results();
   end

   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      results();
   end
endmodule // scp_client_test

// ==== bench/scp_host_model.sv ====
/*
 * host master model for the two-wire bus: start, stop, byte write and read.
 * assumes a pull-up on the data line outside and the core clock for pacing.
 */
`timescale 1ns/1ps
module scp_host_model (
   input wire clk_i,
   input wire sda_i, // resolved data line level
   output logic scl_o, // bus clock, stands high outside frames
   output logic sda_low_o // high pulls the data line low
);
   // ==========================================
   // line primitives
   // ==========================================
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end

   // quarter bit of 5 core cycles, well above the minimum bus rate
   task automatic q(input int n = 5);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // data moves only while the clock is low, sampled mid high phase
   task automatic bit_io(input logic b, output logic s);
      q();
      sda_low_o = ~b;
      q();
      scl_o = 1'b1;
      q();
      s = sda_i;
      q();
      scl_o = 1'b0;
   endtask

   // start or repeated start: data falls while clock high
   task automatic start();
      sda_low_o = 1'b0;
      q();
      scl_o = 1'b1;
      q();
      sda_low_o = 1'b1;
      q();
      scl_o = 1'b0;
   endtask

   task automatic stop();
      q();
      sda_low_o = 1'b1;
      q();
      scl_o = 1'b1;
      q();
      sda_low_o = 1'b0;
      q();
   endtask

   // lets both lines rise with no start or stop between them
   task automatic release_bus();
      sda_low_o = 1'b0;
      q();
      scl_o = 1'b1;
      q();
   endtask

   // ==========================================
   // bytes
   // ==========================================
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(d[i], s);
      bit_io(1'b1, s);
      ack = ~s;
   endtask

   // host acks all but the last byte, which it nacks
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, s);
   endtask
endmodule // scp_host_model

// ==== rtl/scp_client.v ====
/*
 * smbus / i2c client port: byte read and write, block transfers with a
 * wrapping pointer, low-clock timeout and idle reset.
 * assumes a host master on the two wires, pull-ups outside, and a core clock
 * far faster than the bus clock so every bus edge is seen.
 */
// Summary of operation
// - clock low over 30 ms resets client
// - both lines high 200 us resets client, except while SLEEP_I is high
// - both resets off until disable cleared
// - after those resets wait for start
// - works at bus rates up to 400 khz
// - plain i2c multi-byte framing, no count byte
// - write, read, send and receive byte accepted
// - write is address, index, data, stop; acked
// - read uses repeated start, host nacks last
// - index-only write just loads the pointer
// - read without index uses current pointer
// - block write stores, increments, wraps ff to 00
// - block read increments pointer, wraps to 00
// - first byte is address plus direction bit
// - bytes are eight bits, msb first
// - client never stretches the clock line
// - stop resets the client interface
`timescale 1ns/1ps
`include "scp_map.vh"
module scp_client #(
   parameter [6:0] OWN_ADDR = 7'h2a, // client address, plain default
   parameter TIMEOUT_CYC = `SCP_TIMEOUT_CYC,
   parameter IDLE_CYC = `SCP_IDLE_CYC
) (
   input wire REF_CLK_I,
   input wire RST_B_I,
   input wire SERIAL_BUS_CLOCK_I, // bus clock pin level
   input wire SDA_I, // data pin level
   input wire TIMEOUT_DISABLE_BIT_I, // 1 keeps both bus resets off
   input wire SLEEP_I, // sleep state, blocks idle reset
   output reg SDA_O, // always 0, drive is by enable
   output reg SDA_OE_O, // high pulls data low
   output reg SCL_OE_O, // clock line never driven
   output reg BUS_RESET_O // one-cycle pulse on timeout or idle reset
);
   // ==========================================================
   // states
   // ==========================================================
   localparam [2:0] ST_IDLE = 3'd0; // waiting for start
   localparam [2:0] ST_ADDR = 3'd1; // shifting address byte
   localparam [2:0] ST_INDEX = 3'd2; // shifting index byte
   localparam [2:0] ST_WDATA = 3'd3; // shifting write data
   localparam [2:0] ST_RDATA = 3'd4; // sending read data
   localparam [2:0] ST_RACK = 3'd5; // host ack slot
   localparam [2:0] ST_ACK = 3'd6; // client ack slot

   // ==========================================================
   // synchronised pins and edges
   // ==========================================================
   wire scl_s; // synchronised clock
   wire sda_s; // synchronised data
   reg scl_d_reg; // delayed clock for edges
   reg sda_d_reg; // delayed data for edges

   scp_sync u_sync_scl (
      .clk_i(REF_CLK_I),
      .rst_b_i(RST_B_I),
      .d_i(SERIAL_BUS_CLOCK_I),
      .q_o(scl_s)
   );
   scp_sync u_sync_sda (
      .clk_i(REF_CLK_I),
      .rst_b_i(RST_B_I),
      .d_i(SDA_I),
      .q_o(sda_s)
   );

   // edge detection on synchronised levels only
   wire scl_rise = scl_s & ~scl_d_reg;
   wire scl_fall = ~scl_s & scl_d_reg;
   wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // ==========================================================
   // registers
   // ==========================================================
   reg [2:0] state_reg, state_next; // protocol state
   reg [2:0] ret_reg, ret_next; // state after the ack slot
   reg [3:0] bit_reg, bit_next; // bits taken in current byte
   reg [7:0] shift_reg, shift_next; // byte shifter, msb first
   reg [7:0] ptr_reg, ptr_next; // register pointer, kept over transactions
   reg rd_reg, rd_next; // current transaction is a read
   reg sda_oe_next; // next data drive
   reg we_next; // memory write strobe
   reg [24:0] low_cnt_reg; // clock-low timer
   reg [24:0] idle_cnt_reg; // both-high timer
   reg to_fire; // timeout or idle reset this cycle
   reg ack_pend_reg, ack_pend_next; // ack in flight, release on fall
   wire [7:0] rdata; // memory read data

   // default widths give the full 256-entry byte map the 8-bit pointer reaches
   scp_regmem u_mem (
      .clk_i(REF_CLK_I),
      .we_i(we_next),
      .waddr_i(ptr_reg),
      .wdata_i(shift_next),
      .raddr_i(ptr_reg),
      .rdata_o(rdata)
   );

   // ==========================================================
   // timeout and idle timers
   // ==========================================================
   // counters are held at zero while disabled so enabling never fires at once
   always @(posedge REF_CLK_I) begin
      if (!RST_B_I || TIMEOUT_DISABLE_BIT_I) begin
         low_cnt_reg <= 25'h0000000;
         idle_cnt_reg <= 25'h0000000;
      end else begin
         if (scl_s) begin
            low_cnt_reg <= 25'h0000000;
         end else if (low_cnt_reg != TIMEOUT_CYC[24:0]) begin
            low_cnt_reg <= low_cnt_reg + 25'h0000001;
         end
         if (!(scl_s && sda_s) || SLEEP_I) begin
            idle_cnt_reg <= 25'h0000000;
         end else if (idle_cnt_reg != IDLE_CYC[24:0]) begin
            idle_cnt_reg <= idle_cnt_reg + 25'h0000001;
         end
      end
   end

   // fire once when a count passes its limit
   always @* begin
      to_fire = 1'b0;
      if (!TIMEOUT_DISABLE_BIT_I) begin
         if (!scl_s && low_cnt_reg == TIMEOUT_CYC[24:0] - 25'h0000001) begin
            to_fire = 1'b1;
         end
         if (scl_s && sda_s && !SLEEP_I && idle_cnt_reg == IDLE_CYC[24:0] - 25'h0000001) begin
            to_fire = 1'b1;
         end
      end
   end

   // ==========================================================
   // protocol engine
   // ==========================================================
   // all sampling on scl rise, driving changes on scl fall except the release on timeout, start or stop, which keeps
   // data stable while the clock is high when the core clock is far faster than the bus clock.
   always @* begin
      state_next = state_reg;
      ret_next = ret_reg;
      bit_next = bit_reg;
      shift_next = shift_reg;
      ptr_next = ptr_reg;
      rd_next = rd_reg;
      sda_oe_next = SDA_OE_O;
      we_next = 1'b0;
      ack_pend_next = ack_pend_reg;
      if (to_fire) begin
         // release the line, drop the partial byte, wait for start.
         state_next = ST_IDLE;
         sda_oe_next = 1'b0;
         bit_next = 4'h0;
         shift_next = 8'h00;
         ack_pend_next = 1'b0;
      end else if (start_det) begin
         // start or repeated start, pointer kept.
         state_next = ST_ADDR;
         bit_next = 4'h0;
         sda_oe_next = 1'b0;
         ack_pend_next = 1'b0;
      end else if (stop_det) begin
         state_next = ST_IDLE;
         sda_oe_next = 1'b0;
         ack_pend_next = 1'b0;
      end else begin
         case (state_reg)
            ST_ADDR, ST_INDEX, ST_WDATA: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[6:0], sda_s};
                  bit_next = bit_reg + 4'h1;
               end else if (scl_fall && bit_reg == 4'h8) begin
                  bit_next = 4'h0;
                  if (state_reg == ST_ADDR) begin
                     if (shift_reg[7:1] != OWN_ADDR) begin
                        state_next = ST_IDLE;
                     end else begin
                        rd_next = shift_reg[`SCP_DIR_BIT];
                        sda_oe_next = 1'b1;
                        state_next = ST_ACK;
                        // read without index starts at the pointer.
                        ret_next = shift_reg[`SCP_DIR_BIT] ? ST_RDATA : ST_INDEX;
                     end
                  end else if (state_reg == ST_INDEX) begin
                     // index alone loads the pointer only.
                     ptr_next = shift_reg;
                     sda_oe_next = 1'b1;
                     state_next = ST_ACK;
                     ret_next = ST_WDATA;
                  end else begin
                     // store, then step the pointer with 8-bit wrap.
                     we_next = 1'b1;
                     ptr_next = ptr_reg + 8'h01;
                     sda_oe_next = 1'b1;
                     state_next = ST_ACK;
                     ret_next = ST_WDATA; // no count byte, host ends it.
                  end
               end
            end
            ST_ACK: begin
               // hold ack through the ninth clock; on its falling edge release, or for a read drive the first data bit
               if (scl_rise) begin
                  ack_pend_next = 1'b1;
               end else if (scl_fall && ack_pend_reg) begin
                  ack_pend_next = 1'b0;
                  state_next = ret_reg;
                  bit_next = 4'h0;
                  if (ret_reg == ST_RDATA) begin
                     shift_next = rdata;
                     sda_oe_next = ~rdata[7];
                     bit_next = 4'h1;
                  end else begin
                     sda_oe_next = 1'b0;
                  end
               end
            end
            ST_RDATA: begin
               if (scl_fall) begin
                  if (bit_reg == 4'h8) begin
                     // byte out, free the line for the host ack; the pointer
                     // steps only on a host ack, so a nacked single read keeps it.
                     sda_oe_next = 1'b0;
                     state_next = ST_RACK;
                  end else begin
                     sda_oe_next = ~shift_reg[7 - bit_reg[2:0]];
                     bit_next = bit_reg + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  // host nack ends the read, ack asks for more.
                  ret_next = sda_s ? ST_IDLE : ST_RDATA;
                  ack_pend_next = 1'b1;
                  // ack asks for the next register, data fetched before the fall
                  if (!sda_s) begin
                     ptr_next = ptr_reg + 8'h01;
                  end
               end else if (scl_fall && ack_pend_reg) begin
                  ack_pend_next = 1'b0;
                  state_next = ret_reg;
                  if (ret_reg == ST_RDATA) begin
                     shift_next = rdata;
                     sda_oe_next = ~rdata[7];
                     bit_next = 4'h1;
                  end
               end
            end
            ST_IDLE: begin
               sda_oe_next = 1'b0;
            end
            default: begin
               state_next = ST_IDLE;
               sda_oe_next = 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // state and pin flops
   // ==========================================================
   always @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
         state_reg <= ST_IDLE;
         ret_reg <= ST_IDLE;
         bit_reg <= 4'h0;
         shift_reg <= 8'h00;
         ptr_reg <= `SCP_PTR_RST;
         rd_reg <= 1'b0;
         ack_pend_reg <= 1'b0;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         SDA_O <= `SCP_ACK_LVL;
         SDA_OE_O <= 1'b0;
         SCL_OE_O <= 1'b0;
         BUS_RESET_O <= 1'b0;
      end else begin
         state_reg <= state_next;
         ret_reg <= ret_next;
         bit_reg <= bit_next;
         shift_reg <= shift_next;
         ptr_reg <= ptr_next;
         rd_reg <= rd_next;
         ack_pend_reg <= ack_pend_next;
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
         SDA_O <= `SCP_ACK_LVL;
         SDA_OE_O <= sda_oe_next;
         SCL_OE_O <= 1'b0;
         BUS_RESET_O <= to_fire;
      end
   end
endmodule // scp_client

// ==== rtl/scp_map.vh ====
/*
 * constants for the serial client port: timing counts and protocol codes.
 * assumes the core clock runs at 250 mhz and the includer uses plain verilog.
 */
`ifndef SCP_MAP_VH
`define SCP_MAP_VH

// ==========================================================
// clock and timing
// ==========================================================
`define SCP_CLK_HZ 250000000
// low-clock timeout, in microseconds
`define SCP_TIMEOUT_US 30000
// cycles for the timeout, longest time rounds down
`define SCP_TIMEOUT_CYC ((`SCP_CLK_HZ / 1000000) * `SCP_TIMEOUT_US)
// idle reset time, in microseconds
`define SCP_IDLE_US 200
`define SCP_IDLE_CYC ((`SCP_CLK_HZ / 1000000) * `SCP_IDLE_US)

// ==========================================================
// protocol fields
// ==========================================================
// direction bit position in the address byte
`define SCP_DIR_BIT 0
// pointer value after reset
`define SCP_PTR_RST 8'h00
// ack level driven by the client
`define SCP_ACK_LVL 1'b0

`endif

// ==== rtl/scp_regmem.v ====
/*
 * byte-wide register memory addressed by the client pointer.
 * assumes one write port and a registered read port on the same clock.
 */
`timescale 1ns/1ps
module scp_regmem #(
   parameter AW = 8,
   parameter DW = 8
) (
   input wire clk_i,
   input wire we_i,
   input wire [AW-1:0] waddr_i,
   input wire [DW-1:0] wdata_i,
   input wire [AW-1:0] raddr_i,
   output reg [DW-1:0] rdata_o
);
   reg [DW-1:0] mem [0:(1<<AW)-1]; // register contents, no reset

   // ==========================================================
   // write then registered read
   // ==========================================================
   always @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule // scp_regmem

// ==== rtl/scp_sync.v ====
/*
 * two-flop synchroniser for one pin level.
 * assumes the input is asynchronous to clk_i; the first flop feeds only the second.
 */
`timescale 1ns/1ps
module scp_sync (
   input wire clk_i,
   input wire rst_b_i,
   input wire d_i,
   output reg q_o
);
   reg meta_reg; // first stage, read only by q_o

   // ==========================================================
   // two stages, reset to the idle-high bus level
   // ==========================================================
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         meta_reg <= 1'b1;
         q_o <= 1'b1;
      end else begin
         meta_reg <= d_i;
         q_o <= meta_reg;
      end
   end
endmodule // scp_sync
